//--- pkg/owb_cfg.svh
`ifndef OWB_CFG_SVH
`define OWB_CFG_SVH
// ----------------------------------------
// clock and common timing source
// ----------------------------------------
`define OWB_CLK_NS 10
`define OWB_TICK_NS 250
`define OWB_T(ns) (12'((ns) / `OWB_TICK_NS))
// ----------------------------------------
// configuration layout and reset value
// ----------------------------------------
`define OWB_CFG_RST 4'h0
`define OWB_CFG_ACTPU 0
`define OWB_CFG_STRPU 2
`define OWB_CFG_OWS 3
// ----------------------------------------
// slave address, upper six bits (arbitrary)
// ----------------------------------------
`define OWB_I2C_BASE 6'h0c
// ----------------------------------------
// command codes and read pointer codes
// ----------------------------------------
`define OWB_CMD_DEVRST 8'h01
`define OWB_CMD_SETPTR 8'h02
`define OWB_CMD_WCFG 8'h03
`define OWB_CMD_OWRST 8'h04
`define OWB_CMD_BIT 8'h05
`define OWB_CMD_WBYTE 8'h06
`define OWB_CMD_RBYTE 8'h07
`define OWB_CMD_TRIP 8'h08
`define OWB_PTR_STAT 8'h00
`define OWB_PTR_DATA 8'h01
`define OWB_PTR_CFG 8'h02
// ----------------------------------------
// bus waveform times in ns, standard / overdrive
// ----------------------------------------
`define OWB_STD_RSTL_NS 600000
`define OWB_OVD_RSTL_NS 72000
`define OWB_STD_RSTH_NS 584000
`define OWB_OVD_RSTH_NS 74000
`define OWB_STD_MSP_NS 70000
`define OWB_OVD_MSP_NS 7500
`define OWB_STD_SI_NS 8000
`define OWB_OVD_SI_NS 750
`define OWB_STD_SLOT_NS 65000
`define OWB_OVD_SLOT_NS 10000
`define OWB_STD_LOW0_NS 60000
`define OWB_OVD_LOW0_NS 7500
`define OWB_STD_LOW1_NS 6000
`define OWB_OVD_LOW1_NS 1000
`define OWB_STD_SAMP_NS 12000
`define OWB_OVD_SAMP_NS 2000
`define OWB_STD_ACTPU_NS 2500
`define OWB_OVD_ACTPU_NS 500
`endif

//--- pkg/owb_pkg.sv
`default_nettype none
package owb_pkg;
    // bus engine states, one-hot
    typedef enum logic [3:0] {
        OW_IDLE = 4'b0001,
        OW_RSTL = 4'b0010,
        OW_RSTH = 4'b0100,
        OW_SLOT = 4'b1000
    } owb_ow_state_t;
    // host port phases, one-hot
    typedef enum logic [3:0] {
        HP_IDLE = 4'b0001,
        HP_ADDR = 4'b0010,
        HP_WR = 4'b0100,
        HP_RD = 4'b1000
    } owb_hp_state_t;
    typedef struct packed {
        logic ows;
        logic strong_pullup_bit;
        logic zero;
        logic active_pullup_bit;
    } owb_cfg_t;
    typedef struct packed {
        logic dir;
        logic tsb;
        logic sbr;
        logic rst;
        logic ll;
        logic sd;
        logic ppd;
        logic busy;
    } owb_status_t;
endpackage
`default_nettype wire

//--- hw/owb_tick_gen.sv
`default_nettype none
// ----------------------------------------
// one-cycle enable every DIV clocks
// ----------------------------------------
module owb_tick_gen #(
    parameter int unsigned DIV = 25
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // restart aligns the first tick to a waveform start
    input wire logic restart,
    output logic tick
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_r;

    // divider, restarted so no slot begins with a short tick
    always_ff @(posedge clk) begin
        if (srst || restart) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r == CW'(DIV - 1)) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1);
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- hw/owb_bridge.sv
`default_nettype none
`include "owb_cfg.svh"
module owb_bridge import owb_pkg::*; #(
    parameter int unsigned TICK_DIV = (`OWB_TICK_NS + `OWB_CLK_NS - 1) / `OWB_CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host serial port, open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // straps and sleep
    input wire logic addr_select_in,
    input wire logic sleep_request_n,
    output logic sleeping,
    // single-wire line, open drain
    input wire logic owIn,
    output logic owOut,
    output logic owOe,
    // pullup controls
    output logic pullupOn,
    output logic ext_pullup_ctl_n
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] sync1_r, sync2_r;
    logic sclS, sdaS, adS, slpS_n, owS, sclPrev_r, sdaPrev_r;
    always_ff @(posedge clk) begin
        sync1_r <= {owIn, sleep_request_n, addr_select_in, sdaIn, sclIn};
        sync2_r <= sync1_r;
        sclPrev_r <= sync2_r[0];
        sdaPrev_r <= sync2_r[1];
    end
    assign {owS, slpS_n, adS, sdaS, sclS} = sync2_r;
    wire sclRise = sclS & ~sclPrev_r;
    wire sclFall = ~sclS & sclPrev_r;
    wire startC = sclS & sclPrev_r & ~sdaS & sdaPrev_r;
    wire stopC = sclS & sclPrev_r & sdaS & ~sdaPrev_r;

    // ----------------------------------------
    // shared state
    // ----------------------------------------
    owb_cfg_t cfg_r;
    owb_status_t stat_r;
    owb_ow_state_t ow_r;
    owb_hp_state_t hp_r;
    logic [7:0] ptr_r, rdData_r, cmdCode_r, cmdArg_r, hpSh_r, owSh_r;
    logic cmdGo_r, strAct_r;
    wire busy = (ow_r != OW_IDLE);
    wire cmdOk = cmdGo_r & (~busy | (cmdCode_r == `OWB_CMD_DEVRST));
    wire devRst = cmdOk & (cmdCode_r == `OWB_CMD_DEVRST);
    wire cfgWr = cmdOk & (cmdCode_r == `OWB_CMD_WCFG) &
                 (cmdArg_r[7:4] == ~cmdArg_r[3:0]);
    wire owCmd = cmdOk & ((cmdCode_r == `OWB_CMD_OWRST) | (cmdCode_r == `OWB_CMD_BIT) |
                 (cmdCode_r == `OWB_CMD_WBYTE) | (cmdCode_r == `OWB_CMD_RBYTE) |
                 (cmdCode_r == `OWB_CMD_TRIP));
    wire sleepNow = ~slpS_n;
    wire [6:0] myAddr = {`OWB_I2C_BASE, adS};

    // read pointer selects what the host reads
    logic [7:0] rdByte;
    always_comb begin
        case (ptr_r)
            `OWB_PTR_DATA: rdByte = rdData_r;
            `OWB_PTR_CFG: rdByte = {4'h0, cfg_r};
            default: rdByte = stat_r;
        endcase
    end

    // ----------------------------------------
    // host serial slave, oversampled so 0..400 kHz all work
    // ----------------------------------------
    logic [3:0] hpBit_r;
    logic hpAck_r, hpByte1_r, hpByte2_r;
    wire needArg = (hpSh_r == `OWB_CMD_SETPTR) | (hpSh_r == `OWB_CMD_WCFG) |
                   (hpSh_r == `OWB_CMD_BIT) | (hpSh_r == `OWB_CMD_WBYTE) |
                   (hpSh_r == `OWB_CMD_TRIP);
    always_ff @(posedge clk) begin
        cmdGo_r <= 1'b0;
        sdaOut <= 1'b0;
        if (srst || sleepNow || stopC) begin
            hp_r <= HP_IDLE;
            sdaOe <= 1'b0;
            hpAck_r <= 1'b0;
            if (srst) begin
                hpBit_r <= 4'h0;
                hpSh_r <= 8'h00;
                hpByte1_r <= 1'b0;
                hpByte2_r <= 1'b0;
                cmdCode_r <= 8'h00;
                cmdArg_r <= 8'h00;
            end
        end else if (startC) begin
            hp_r <= HP_ADDR;
            hpBit_r <= 4'h0;
            hpAck_r <= 1'b0;
            sdaOe <= 1'b0;
        end else if (hp_r != HP_IDLE && sclRise) begin
            if (hpBit_r != 4'h8) begin
                hpBit_r <= hpBit_r + 4'h1;
                if (hp_r != HP_RD)
                    hpSh_r <= {hpSh_r[6:0], sdaS};
            end else if (hp_r == HP_RD && hpAck_r && sdaS) begin
                hp_r <= HP_IDLE; // host refused another byte
            end
        end else if (hp_r != HP_IDLE && sclFall) begin
            if (hpBit_r == 4'h8 && !hpAck_r) begin
                hpAck_r <= 1'b1;
                sdaOe <= 1'b0;
                if (hp_r == HP_ADDR) begin
                    if (hpSh_r[7:1] == myAddr)
                        sdaOe <= 1'b1;
                    else
                        hp_r <= HP_IDLE;
                end else if (hp_r == HP_WR) begin
                    sdaOe <= 1'b1;
                    if (!hpByte1_r) begin
                        cmdCode_r <= hpSh_r;
                        hpByte1_r <= 1'b1;
                        cmdGo_r <= ~needArg;
                        hpByte2_r <= ~needArg;
                    end else if (!hpByte2_r) begin
                        cmdArg_r <= hpSh_r;
                        cmdGo_r <= 1'b1;
                        hpByte2_r <= 1'b1;
                    end
                end
            end else if (hpBit_r == 4'h8) begin
                hpAck_r <= 1'b0;
                hpBit_r <= 4'h0;
                sdaOe <= 1'b0;
                if (hp_r == HP_ADDR) begin
                    hp_r <= hpSh_r[0] ? HP_RD : HP_WR;
                    hpByte1_r <= 1'b0;
                    hpByte2_r <= 1'b0;
                end
                if (hp_r == HP_RD || (hp_r == HP_ADDR && hpSh_r[0])) begin
                    sdaOe <= ~rdByte[7];
                    hpSh_r <= {rdByte[6:0], 1'b0};
                end
            end else if (hp_r == HP_RD && hpBit_r != 4'h0) begin
                sdaOe <= ~hpSh_r[7];
                hpSh_r <= {hpSh_r[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // configuration and read pointer
    // ----------------------------------------
    logic strEnd;
    always_ff @(posedge clk) begin
        if (srst || devRst) begin
            cfg_r <= `OWB_CFG_RST;
        end else if (cfgWr) begin
            cfg_r <= {cmdArg_r[`OWB_CFG_OWS], cmdArg_r[`OWB_CFG_STRPU], 1'b0,
                      cmdArg_r[`OWB_CFG_ACTPU]};
        end else if (strEnd) begin
            cfg_r.strong_pullup_bit <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || devRst || owCmd)
            ptr_r <= `OWB_PTR_STAT;
        else if (cmdOk && cmdCode_r == `OWB_CMD_SETPTR)
            ptr_r <= cmdArg_r;
        else if (cfgWr)
            ptr_r <= `OWB_PTR_CFG;
    end

    // ----------------------------------------
    // bus engine timing, all from one tick source
    // ----------------------------------------
    logic tick;
    owb_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .clk(clk),
        .srst(srst),
        .restart(owCmd),
        .tick(tick)
    );
    wire ovd = cfg_r.ows;
    wire [11:0] tRstL = ovd ? `OWB_T(`OWB_OVD_RSTL_NS) : `OWB_T(`OWB_STD_RSTL_NS);
    wire [11:0] tRstH = ovd ? `OWB_T(`OWB_OVD_RSTH_NS) : `OWB_T(`OWB_STD_RSTH_NS);
    wire [11:0] tMsp = ovd ? `OWB_T(`OWB_OVD_MSP_NS) : `OWB_T(`OWB_STD_MSP_NS);
    wire [11:0] tSi = ovd ? `OWB_T(`OWB_OVD_SI_NS) : `OWB_T(`OWB_STD_SI_NS);
    wire [11:0] tSlot = ovd ? `OWB_T(`OWB_OVD_SLOT_NS) : `OWB_T(`OWB_STD_SLOT_NS);
    wire [11:0] tLow0 = ovd ? `OWB_T(`OWB_OVD_LOW0_NS) : `OWB_T(`OWB_STD_LOW0_NS);
    wire [11:0] tLow1 = ovd ? `OWB_T(`OWB_OVD_LOW1_NS) : `OWB_T(`OWB_STD_LOW1_NS);
    wire [11:0] tSamp = ovd ? `OWB_T(`OWB_OVD_SAMP_NS) : `OWB_T(`OWB_STD_SAMP_NS);
    wire [11:0] tActPu = ovd ? `OWB_T(`OWB_OVD_ACTPU_NS) : `OWB_T(`OWB_STD_ACTPU_NS);

    logic [11:0] cnt_r;
    logic [2:0] slot_r, last_r;
    logic [7:0] op_r;
    logic txBit, sampBit_r;
    wire [11:0] cntInc = cnt_r + 12'h001;
    wire tripDir = (stat_r.sbr != stat_r.tsb) ? stat_r.sbr : (stat_r.sbr | cmdArg_r[7]);
    always_comb begin
        case (op_r)
            `OWB_CMD_WBYTE: txBit = owSh_r[0];
            `OWB_CMD_BIT: txBit = cmdArg_r[7];
            `OWB_CMD_TRIP: txBit = (slot_r == 3'h2) ? tripDir : 1'b1;
            default: txBit = 1'b1;
        endcase
    end
    wire [11:0] tLow = txBit ? tLow1 : tLow0;
    wire relEdge = (ow_r == OW_SLOT) & tick & (cntInc == tLow);
    wire strStart = relEdge & (slot_r == last_r) & cfg_r.strong_pullup_bit &
                    ((op_r == `OWB_CMD_WBYTE) | (op_r == `OWB_CMD_BIT));

    // sequencer runs each command to the end on its own unless device reset or sleep aborts it
    always_ff @(posedge clk) begin
        if (srst || devRst || sleepNow) begin
            ow_r <= OW_IDLE;
            cnt_r <= 12'h000;
            slot_r <= 3'h0;
            last_r <= 3'h0;
            op_r <= 8'h00;
            owSh_r <= 8'h00;
            sampBit_r <= 1'b0;
        end else if (owCmd) begin
            op_r <= cmdCode_r;
            cnt_r <= 12'h000;
            slot_r <= 3'h0;
            owSh_r <= (cmdCode_r == `OWB_CMD_WBYTE) ? cmdArg_r : 8'hff;
            last_r <= (cmdCode_r == `OWB_CMD_TRIP) ? 3'h2 :
                      (cmdCode_r == `OWB_CMD_BIT) ? 3'h0 : 3'h7;
            ow_r <= (cmdCode_r == `OWB_CMD_OWRST) ? OW_RSTL : OW_SLOT;
        end else if (tick) begin
            cnt_r <= cntInc;
            case (ow_r)
                OW_RSTL: if (cntInc == tRstL) begin
                    ow_r <= OW_RSTH;
                    cnt_r <= 12'h000;
                end
                OW_RSTH: if (cntInc == tRstH)
                    ow_r <= OW_IDLE;
                OW_SLOT: begin
                    if (cntInc == tSamp)
                        sampBit_r <= owS;
                    if (cntInc == tSlot) begin
                        cnt_r <= 12'h000;
                        slot_r <= slot_r + 3'h1;
                        // shift only at slot end, so the bit being driven holds its low time
                        if (op_r != `OWB_CMD_BIT && op_r != `OWB_CMD_TRIP)
                            owSh_r <= {sampBit_r, owSh_r[7:1]};
                        if (slot_r == last_r)
                            ow_r <= OW_IDLE;
                    end
                end
                default: ow_r <= OW_IDLE;
            endcase
        end
    end

    // status and read data; busy and ll refreshed every cycle, the rest only by the commands that own them
    always_ff @(posedge clk) begin
        if (srst || devRst) begin
            stat_r <= '0;
            stat_r.rst <= 1'b1;
            rdData_r <= 8'h00;
        end else begin
            stat_r.busy <= busy | owCmd;
            stat_r.ll <= owS;
            if (cfgWr)
                stat_r.rst <= 1'b0;
            if (owCmd && cmdCode_r == `OWB_CMD_OWRST) begin
                stat_r.sd <= 1'b0;
                stat_r.ppd <= 1'b0;
            end
            if (tick && ow_r == OW_RSTH && cntInc == tSi && !owS)
                stat_r.sd <= 1'b1;
            if (tick && ow_r == OW_RSTH && cntInc == tMsp && !owS && !stat_r.sd)
                stat_r.ppd <= 1'b1;
            if (tick && ow_r == OW_SLOT && cntInc == tSamp) begin
                if (op_r == `OWB_CMD_BIT || (op_r == `OWB_CMD_TRIP && slot_r == 3'h0))
                    stat_r.sbr <= owS;
                if (op_r == `OWB_CMD_TRIP && slot_r == 3'h1)
                    stat_r.tsb <= owS;
                if (op_r == `OWB_CMD_TRIP && slot_r == 3'h2)
                    stat_r.dir <= tripDir;
            end
            if (ow_r == OW_IDLE && busy == 1'b0 && stat_r.busy && op_r == `OWB_CMD_RBYTE)
                rdData_r <= owSh_r;
        end
    end

    // ----------------------------------------
    // line drive and pullups
    // ----------------------------------------
    logic actArm_r;
    logic [11:0] actCnt_r;
    // sleep ends the strong pullup too, so its config bit clears then as well
    assign strEnd = strAct_r &
                    (owCmd | sleepNow | (cfgWr & ~cmdArg_r[`OWB_CFG_STRPU]));
    always_ff @(posedge clk) begin
        owOut <= 1'b0;
        if (srst || sleepNow)
            owOe <= 1'b0;
        else
            owOe <= (ow_r == OW_RSTL) | ((ow_r == OW_SLOT) & (cnt_r < tLow));
    end
    // active pullup only after our own slot release, never after a presence pulse
    always_ff @(posedge clk) begin
        if (srst || devRst || sleepNow || owCmd) begin
            actArm_r <= 1'b0;
            actCnt_r <= 12'h000;
        end else begin
            if (relEdge && cfg_r.active_pullup_bit)
                actArm_r <= 1'b1;
            else if (actArm_r && owS) begin
                actArm_r <= 1'b0;
                actCnt_r <= tActPu;
            end else if (tick && actCnt_r != 12'h000)
                actCnt_r <= actCnt_r - 12'h001;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || devRst || sleepNow)
            strAct_r <= 1'b0;
        else if (strEnd)
            strAct_r <= 1'b0;
        else if (strStart)
            strAct_r <= 1'b1;
    end
    // one pullup transistor serves both policies
    always_ff @(posedge clk) begin
        if (srst || sleepNow) begin
            pullupOn <= 1'b0;
            ext_pullup_ctl_n <= 1'b1;
            sleeping <= ~srst & sleepNow;
        end else begin
            pullupOn <= strAct_r | (actCnt_r != 12'h000);
            ext_pullup_ctl_n <= ~strAct_r;
            sleeping <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- tb/owb_bridge_properties.sv
`default_nettype none
module owb_bridge_chk #(
    parameter int unsigned TICK_DIV = 25
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // sleep and host port
    input wire logic sleep_request_n,
    input wire logic sleeping,
    input wire logic sdaOe,
    // line drive and pullups
    input wire logic owOe,
    input wire logic pullupOn,
    input wire logic ext_pullup_ctl_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // run-length helpers
    // ----------------------------------------
    localparam int TD = TICK_DIV;
    localparam int TOL = 2 * TD + 4;
    logic [15:0] lowCnt_r;
    logic [15:0] puCnt_r;
    logic lenOk;
    logic actOk;
    // tolerance covers tick alignment at waveform start
    function automatic logic near(input logic [15:0] c, input int t);
        return (int'(c) >= t * TD - TOL) && (int'(c) <= t * TD + TOL);
    endfunction
    // cycles the line has been held low
    always_ff @(posedge clk) begin
        lowCnt_r <= (srst || !owOe) ? 16'h0000 : lowCnt_r + 16'h0001;
    end
    // cycles the pullup has been on
    always_ff @(posedge clk) begin
        puCnt_r <= (srst || !pullupOn) ? 16'h0000 : puCnt_r + 16'h0001;
    end
    // legal low times in ticks, standard then overdrive
    assign lenOk = near(lowCnt_r, 24) || near(lowCnt_r, 240) || near(lowCnt_r, 2400)
        || near(lowCnt_r, 4) || near(lowCnt_r, 30) || near(lowCnt_r, 288);
    assign actOk = near(puCnt_r, 10) || near(puCnt_r, 2);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_rst_idle: assert property ($past(srst) |-> ext_pullup_ctl_n && !owOe
        && !pullupOn && !sdaOe) else $error("outputs not idle after reset");
    chk_strong_ext: assert property (!ext_pullup_ctl_n |-> pullupOn)
        else $error("external pullup without internal pullup");
    chk_strong_no_low: assert property (!ext_pullup_ctl_n |-> !owOe)
        else $error("strong pullup while line driven low");
    chk_pull_rise: assert property ($rose(pullupOn) |-> !owOe)
        else $error("pullup started while line driven low");
    chk_act_ontime: assert property ($fell(pullupOn) && $past(ext_pullup_ctl_n)
        && !sleeping |-> actOk) else $error("active pullup on-time wrong");
    chk_low_len: assert property ($fell(owOe) && !sleeping |-> lenOk)
        else $error("line low time off grid");
    chk_sleep_enter: assert property (!sleep_request_n [*5] |-> sleeping)
        else $error("sleep not entered");
    chk_sleep_leave: assert property (sleep_request_n [*5] |-> !sleeping)
        else $error("sleep not left");
    chk_sleep_quiet: assert property (sleeping ##1 sleeping |-> !owOe
        && !pullupOn && ext_pullup_ctl_n) else $error("drive active in sleep");
    chk_sleep_no_ack: assert property (sleeping ##1 sleeping |-> !sdaOe)
        else $error("host port answers in sleep");
endmodule
`default_nettype wire

//--- tb/owb_host_model.sv
`default_nettype none
module owb_host_model #(
    parameter int Q = 65
) (
    // clock
    input wire logic clk,
    // open-drain host serial pins
    input wire logic sdaLine,
    output logic scl,
    output logic sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idle at time zero
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // four quarters a bit keeps the rate under 400 kHz
    task automatic pause;
        repeat (Q) @(posedge clk);
    endtask
    // data set while clock low, sampled while clock high
    task automatic bit_io(input logic b, output logic r);
        sdaPull <= !b;
        pause();
        scl <= 1'b1;
        pause();
        r = sdaLine;
        pause();
        scl <= 1'b0;
        pause();
    endtask
    task automatic start;
        sdaPull <= 1'b1;
        pause();
        scl <= 1'b0;
        pause();
    endtask
    task automatic stop;
        sdaPull <= 1'b1;
        pause();
        scl <= 1'b1;
        pause();
        sdaPull <= 1'b0;
        pause();
        pause();
    endtask
    // msb first, ack bit read back
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
`include "owb_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    localparam int TD = 2;
    localparam logic [6:0] SLV = {`OWB_I2C_BASE, 1'b1};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sleepN = 1'b1;
    logic scl, hostPull, sdaLine, sdaOe, sdaOut, owOe, owOut, owIn, pullupOn, extN, sleeping;
    logic [15:0] lowLen = 16'h0000;
    logic [10:0] presCnt = 11'h000;
    logic [7:0] capBits = 8'h00;
    logic [7:0] d;
    logic a;
    int badCount = 0;
    int nCompared = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    // open-drain wires: pulled high unless someone pulls low
    assign sdaLine = !(hostPull || (sdaOe && !sdaOut));
    assign owIn = !(owOe || (presCnt > 11'd120));
    owb_host_model i_host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaPull(hostPull));
    owb_bridge #(.TICK_DIV(TD)) i_dut (.clk(clk), .srst(srst), .sclIn(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_in(1'b1),
        .sleep_request_n(sleepN), .sleeping(sleeping), .owIn(owIn), .owOut(owOut),
        .owOe(owOe), .pullupOn(pullupOn), .ext_pullup_ctl_n(extN));
    // far-end slave: presence after a long low, slot lengths decoded lsb first
    always @(posedge clk) begin
        lowLen <= owOe ? lowLen + 16'h0001 : 16'h0000;
        if (presCnt != 11'd0) begin
            presCnt <= (presCnt == 11'd1080) ? 11'd0 : presCnt + 11'd1;
        end
        if (!owOe && lowLen > 16'd2000) begin
            presCnt <= 11'd1;
        end else if (!owOe && lowLen != 16'h0000) begin
            capBits <= {lowLen < 16'd200, capBits[7:1]};
        end
    end
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 140000) begin
            badCount = badCount + 1;
            close_out();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared = nCompared + 1;
        if (seen !== exp) begin
            badCount = badCount + 1;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] arg, input logic hasArg);
        i_host.start();
        i_host.wbyte({SLV, 1'b0}, a);
        i_host.wbyte(c, a);
        if (hasArg) begin
            i_host.wbyte(arg, a);
        end
        i_host.stop();
    endtask
    task automatic rd(output logic [7:0] v);
        i_host.start();
        i_host.wbyte({SLV, 1'b1}, a);
        i_host.rbyte(1'b1, v);
        i_host.stop();
    endtask
    // bounded poll until busy drops
    task automatic idle_wait;
        for (int i = 0; i < 12; i++) begin
            rd(d);
            if (d[0] === 1'b0) begin
                break;
            end
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_cfg;
        i_host.start();
        i_host.wbyte({`OWB_I2C_BASE, 1'b0, 1'b0}, a);
        i_host.stop();
        check({7'h00, a}, 8'h00);
        cmd(`OWB_CMD_SETPTR, `OWB_PTR_CFG, 1'b1);
        cmd(`OWB_CMD_WCFG, 8'h11, 1'b1);
        rd(d);
        check(d, 8'h00);
        cmd(`OWB_CMD_WCFG, 8'he1, 1'b1);
        rd(d);
        check(d, 8'h01);
    endtask
    task automatic s_presence;
        cmd(`OWB_CMD_OWRST, 8'h00, 1'b0);
        idle_wait();
        check(d & 8'h07, 8'h02);
    endtask
    task automatic s_strong;
        cmd(`OWB_CMD_WCFG, 8'ha5, 1'b1);
        cmd(`OWB_CMD_WBYTE, 8'h3c, 1'b1);
        idle_wait();
        check(capBits, 8'h3c);
        check({6'h00, extN, pullupOn}, 8'h01);
    endtask
    task automatic s_sleep;
        sleepN <= 1'b0;
        repeat (10) @(posedge clk);
        check({5'h00, sleeping, extN, pullupOn}, 8'h06);
        i_host.start();
        i_host.wbyte({SLV, 1'b0}, a);
        i_host.stop();
        check({7'h00, a}, 8'h00);
        sleepN <= 1'b1;
        repeat (10000) @(posedge clk);
        cmd(`OWB_CMD_SETPTR, `OWB_PTR_CFG, 1'b1);
        rd(d);
        check(d, 8'h01);
    endtask
    task automatic close_out;
        if (badCount == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence: reset, settle wait, then scenarios
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (10000) @(posedge clk);
        s_cfg();
        s_presence();
        s_strong();
        s_sleep();
        close_out();
    end
endmodule
bind owb_bridge owb_bridge_chk #(.TICK_DIV(TICK_DIV)) i_chk (.clk(clk), .srst(srst),
    .sleep_request_n(sleep_request_n), .sleeping(sleeping), .sdaOe(sdaOe), .owOe(owOe),
    .pullupOn(pullupOn), .ext_pullup_ctl_n(ext_pullup_ctl_n));
`default_nettype wire
